// ---- hw/mtp_access_cfg.svh ----
// timing, command codes and memory map constants for the memory access handler
`ifndef MTP_ACCESS_CFG_SVH
`define MTP_ACCESS_CFG_SVH
`define CMD_ADDR_LOAD 8'h10
`define CMD_WRITE_BYTE 8'h12
`define CMD_READ_BYTE 8'h14
`define USER2_LO 16'h0080
`define USER2_HI 16'h03FF
`define USER1_LO 16'h0012
`define USER1_HI 16'h003E
`define CFG_A_LO 16'h0000
`define CFG_A_HI 16'h0010
`define CFG_B_LO 16'h0050
`define CFG_B_HI 16'h007E
`define RSVD_LO 16'h0040
`define RSVD_HI 16'h004E
`define OWN_ADDR_RESET 7'h22
`define CLK_MHZ 20
`define WRITE_TIME_NS 1000
`define WRITE_CYCLES ((`WRITE_TIME_NS * `CLK_MHZ + 999) / 1000)
`define READ_CYCLES 2
`define MEM_WORDS 1024
`endif

// ---- hw/mtp_access_pkg.sv ----
// types shared by the memory access handler
package mtp_access_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR_HI = 3'b001,
    ST_ADDR_LO = 3'b011,
    ST_WDATA = 3'b010,
    ST_RDATA = 3'b110,
    ST_DRAIN = 3'b111
  } cmd_state_t;
  typedef struct packed {
    logic start;
    logic stop;
    logic byte_valid;
    logic [7:0] byte_data;
    logic gen_call;
  } bus_evt_t;
  typedef struct packed {
    logic ack_valid;
    logic ack;
    logic rd_valid;
    logic [7:0] rd_data;
  } bus_resp_t;
endpackage

// ---- hw/mtp_array.sv ----
// nonvolatile array model with busy timing and write protection
`timescale 1ns/10ps
`default_nettype none
`include "mtp_access_cfg.svh"
module mtp_array (
  input wire logic core_clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic wr_start, // start a one byte program
  input wire logic rd_start, // start a one byte fetch
  input wire logic [15:0] addr, // word address
  input wire logic [7:0] wdata, // byte to program
  output logic busy, // access in progress
  output logic [7:0] rdata // fetched byte
);
  logic [7:0] mem_q [`MEM_WORDS];
  logic [15:0] cnt_q;
  logic wr_pend_q;
  logic [15:0] addr_q;
  logic [7:0] wdata_q;
  logic prot;
  // reserved range rejects programming, contents unchanged
  assign prot = (addr_q >= `RSVD_LO) && (addr_q <= `RSVD_HI);
  assign busy = (cnt_q != 16'h0000);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 16'h0000;
      wr_pend_q <= 1'b0;
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
    end else if (!busy && wr_start) begin
      cnt_q <= 16'(`WRITE_CYCLES);
      wr_pend_q <= 1'b1;
      addr_q <= addr;
      wdata_q <= wdata;
    end else if (!busy && rd_start) begin
      cnt_q <= 16'(`READ_CYCLES);
      wr_pend_q <= 1'b0;
      addr_q <= addr;
    end else if (busy) begin
      cnt_q <= cnt_q - 16'h0001;
      if (cnt_q == 16'h0001) begin
        wr_pend_q <= 1'b0;
      end
    end
  end

  // user areas and writable config areas program freely
  genvar gi;
  generate
    for (gi = 0; gi < `MEM_WORDS; gi++) begin : g_word
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          mem_q[gi] <= 8'hFF;
        end else if (wr_pend_q && cnt_q == 16'h0001 && !prot && addr_q == 16'(gi)) begin
          mem_q[gi] <= wdata_q;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (!wr_pend_q && cnt_q == 16'h0001) begin
      rdata <= (addr_q < 16'(`MEM_WORDS)) ? mem_q[addr_q[9:0]] : 8'hFF;
    end
  end
endmodule
`default_nettype wire

// ---- hw/mtp_access.sv ----
// general-call command handler giving an i2c master access to the nonvolatile array
// How it works
// - decode commands 10h, 12h and 14h
// - address load takes two following bytes
// - write takes one byte, programs loaded address
// - read returns byte at loaded address
// - address load ack reports idle, nak busy
// - busy naks command and data phases
// - address register changes only when idle
// - program starts after full data byte
// - no program unless both phases acked
// - read command acked only when serviceable
// - user area two freely read and written
// - user area one read and written
// - writable config ranges read and written
// - reserved range writes fail, unchanged
// - own slave address defaults to 22h
`timescale 1ns/10ps
`default_nettype none
`include "mtp_access_cfg.svh"
module mtp_access (
  input wire logic core_clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire mtp_access_pkg::bus_evt_t evt, // framed bus events from the i2c front end
  output mtp_access_pkg::bus_resp_t resp, // ack answer and read byte
  output logic [6:0] own_addr, // ordinary slave address
  output logic mem_busy, // array busy
  output logic [15:0] mem_addr // loaded word address
);
  import mtp_access_pkg::*;

  cmd_state_t state_q;
  logic [7:0] addr_hi_q;
  logic [15:0] addr_q;
  logic wr_start_q;
  logic rd_start_q;
  logic [7:0] wdata_q;
  logic busy;
  logic [7:0] arr_rdata;
  logic rd_wait_q;
  logic busy_at_cmd_q;
  logic ack_valid_q;
  logic ack_q;
  logic rd_valid_q;
  logic [7:0] rd_data_q;
  logic byte_in;
  logic cmd_known;
  logic cmd_is_rd;
  logic mem_engaged;

  // one clean byte strobe, framing events take priority
  assign byte_in = evt.byte_valid && !evt.start && !evt.stop;

  // only the three memory commands of a general call get an answer
  always_comb begin
    cmd_known = 1'b0;
    cmd_is_rd = 1'b0;
    if (evt.gen_call) begin
      case (evt.byte_data)
        `CMD_ADDR_LOAD: cmd_known = 1'b1;
        `CMD_WRITE_BYTE: cmd_known = 1'b1;
        `CMD_READ_BYTE: begin
          cmd_known = 1'b1;
          cmd_is_rd = 1'b1;
        end
        default: cmd_known = 1'b0;
      endcase
    end
  end

  // array working, or a fetched byte not yet handed over
  assign mem_engaged = busy || rd_wait_q;

  // answer fields each come from their own flip-flop
  assign resp = {ack_valid_q, ack_q, rd_valid_q, rd_data_q};

  mtp_array u_array (
    .core_clk(core_clk),
    .rstn(rstn),
    .wr_start(wr_start_q),
    .rd_start(rd_start_q),
    .addr(addr_q),
    .wdata(wdata_q),
    .busy(busy),
    .rdata(arr_rdata)
  );

  // command sequencer
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      busy_at_cmd_q <= 1'b0;
    end else if (evt.start || evt.stop) begin
      state_q <= ST_IDLE;
    end else if (evt.byte_valid) begin
      case (state_q)
        ST_IDLE: begin
          busy_at_cmd_q <= busy || rd_wait_q;
          if (evt.gen_call) begin
            case (evt.byte_data)
              `CMD_ADDR_LOAD: state_q <= ST_ADDR_HI;
              `CMD_WRITE_BYTE: state_q <= ST_WDATA;
              `CMD_READ_BYTE: state_q <= ST_RDATA;
              default: state_q <= ST_DRAIN;
            endcase
          end else begin
            state_q <= ST_DRAIN;
          end
        end
        ST_ADDR_HI: state_q <= ST_ADDR_LO;
        default: state_q <= ST_DRAIN;
      endcase
    end
  end

  // ack answers: unknown commands and foreign frames get none
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ack_valid_q <= 1'b0;
    end else begin
      ack_valid_q <= byte_in && (state_q != ST_DRAIN) && (state_q != ST_IDLE || cmd_known);
    end
  end

  // busy state decides ack or nak
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ack_q <= 1'b0;
    end else if (state_q == ST_IDLE) begin
      ack_q <= !mem_engaged;
    end else begin
      ack_q <= !(busy || busy_at_cmd_q);
    end
  end

  // address register, msb first, only while idle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      addr_hi_q <= 8'h00;
      addr_q <= 16'h0000;
    end else if (evt.byte_valid && !evt.start && !evt.stop && !busy && !busy_at_cmd_q) begin
      if (state_q == ST_ADDR_HI) begin
        addr_hi_q <= evt.byte_data;
      end else if (state_q == ST_ADDR_LO) begin
        addr_q <= {addr_hi_q, evt.byte_data};
      end
    end
  end

  // program after full data byte with both phases acked
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_start_q <= 1'b0;
      wdata_q <= 8'h00;
    end else begin
      wr_start_q <= evt.byte_valid && !evt.start && !evt.stop && state_q == ST_WDATA &&
                    !busy && !busy_at_cmd_q;
      if (evt.byte_valid && state_q == ST_WDATA) begin
        wdata_q <= evt.byte_data;
      end
    end
  end

  // fetch on acked read command, present byte when ready
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_start_q <= 1'b0;
      rd_wait_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_data_q <= 8'h00;
    end else begin
      rd_start_q <= byte_in && state_q == ST_IDLE && cmd_is_rd && !mem_engaged;
      if (rd_start_q) begin
        rd_wait_q <= 1'b1;
        rd_valid_q <= 1'b0;
      end else if (rd_wait_q && !busy) begin
        rd_wait_q <= 1'b0;
        rd_valid_q <= 1'b1;
        rd_data_q <= arr_rdata;
      end else if (evt.stop || evt.start) begin
        rd_valid_q <= 1'b0;
      end
    end
  end

  // own address held in configuration, separate from general call
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      own_addr <= `OWN_ADDR_RESET;
    end else begin
      own_addr <= own_addr;
    end
  end

  // busy as seen from the bus, fetch included
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mem_busy <= 1'b0;
    end else begin
      mem_busy <= mem_engaged;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mem_addr <= 16'h0000;
    end else begin
      mem_addr <= addr_q;
    end
  end
endmodule
`default_nettype wire

// ---- bench/mtp_access_props.sv ----
// port checker for the memory access handler
`timescale 1ns/10ps
`default_nettype none
module mtp_access_props (
  input wire logic core_clk, // clock
  input wire logic rstn, // reset
  input wire mtp_access_pkg::bus_evt_t evt, // bus events
  input wire mtp_access_pkg::bus_resp_t resp, // answers
  input wire logic [6:0] own_addr, // slave address
  input wire logic mem_busy, // array busy
  input wire logic [15:0] mem_addr // loaded address
);
  import mtp_access_pkg::*;
  logic [7:0] since_ack_q;
  // cycles since the last positive acknowledge
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) since_ack_q <= 8'hFF;
    else if (resp.ack_valid && resp.ack) since_ack_q <= 8'h00;
    else if (since_ack_q != 8'hFF) since_ack_q <= since_ack_q + 8'h01;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_ack_has_byte: assert property (resp.ack_valid |-> $past(evt.byte_valid && evt.gen_call))
    else $error("answer without a general call byte");
  a_busy_gets_nak: assert property (evt.byte_valid && evt.gen_call && mem_busy |=> !(resp.ack_valid && resp.ack))
    else $error("byte acknowledged while busy");
  a_addr_idle_only: assert property ($changed(mem_addr) |-> !$past(mem_busy))
    else $error("address changed while busy");
  a_addr_from_byte: assert property ($changed(mem_addr) |-> $past(evt.byte_valid) || $past(evt.byte_valid, 2))
    else $error("address changed without a byte");
  a_own_addr_fixed: assert property (own_addr == 7'h22)
    else $error("own address wrong");
  a_rd_data_holds: assert property (resp.rd_valid && !evt.start && !evt.stop && !evt.byte_valid |=> resp.rd_valid)
    else $error("read data dropped early");
  a_busy_after_ack: assert property ($rose(mem_busy) |-> since_ack_q <= 8'h04)
    else $error("access started without acknowledge");
  a_rd_after_ack: assert property ($rose(resp.rd_valid) |-> since_ack_q <= 8'h08)
    else $error("read data without acknowledge");
endmodule
bind mtp_access mtp_access_props u_props (.core_clk(core_clk), .rstn(rstn), .evt(evt), .resp(resp),
  .own_addr(own_addr), .mem_busy(mem_busy), .mem_addr(mem_addr));
`default_nettype wire

// ---- bench/mtp_master.sv ----
// bus master model issuing framed events
`timescale 1ns/10ps
`default_nettype none
module mtp_master (
  input wire logic core_clk, // clock
  output mtp_access_pkg::bus_evt_t evt, // events to the handler
  input wire mtp_access_pkg::bus_resp_t resp // answers
);
  import mtp_access_pkg::*;
  initial evt = '0;
  // one event pulse, general call level kept
  task ev(input logic [11:0] v);
    @(posedge core_clk);
    evt <= v;
    @(posedge core_clk);
    evt <= {3'b000, v[8:0]};
  endtask
  // byte out, returns {answer seen, ack}
  task put(input logic [7:0] b, output logic [1:0] r);
    ev({3'b001, b, evt.gen_call});
    r = 2'b00;
    repeat (3) begin
      #1;
      if (r[1] == 1'b0 && resp.ack_valid === 1'b1) r = {1'b1, resp.ack};
      @(posedge core_clk);
    end
  endtask
  // waits for read data; no data gives unknown so the caller's check fails
  task get(output logic [7:0] d);
    repeat (20) if (resp.rd_valid !== 1'b1) begin
      @(posedge core_clk);
      #1;
    end
    d = (resp.rd_valid === 1'b1) ? resp.rd_data : 8'hxx;
  endtask
endmodule
`default_nettype wire

// ---- bench/i2c_mtp_memory_access_tb_top.sv ----
// testbench for the memory access handler
`timescale 1ns/10ps
`default_nettype none
module i2c_mtp_memory_access_tb_top;
  import mtp_access_pkg::*;
  typedef struct {logic [15:0] a; logic [7:0] w; logic [7:0] e;} row_t;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  bus_evt_t evt;
  bus_resp_t resp;
  logic [6:0] own_addr;
  logic mem_busy;
  logic [15:0] mem_addr;
  int error_cnt = 0;
  int tests_run = 0;
  logic [1:0] r;
  logic [7:0] d;
  row_t rows[9] = '{
    '{16'h0080, 8'hA5, 8'hA5}, '{16'h03FF, 8'h3C, 8'h3C},
    '{16'h0012, 8'h11, 8'h11}, '{16'h003E, 8'hE1, 8'hE1},
    '{16'h0000, 8'h01, 8'h01}, '{16'h007E, 8'h7E, 8'h7E},
    '{16'h0040, 8'h00, 8'hFF}, '{16'h004E, 8'h12, 8'hFF},
    '{16'h0400, 8'h55, 8'hFF}};
  always #25 core_clk = ~core_clk;
  mtp_access u_mtp_access (.core_clk(core_clk), .rstn(rstn), .evt(evt), .resp(resp),
    .own_addr(own_addr), .mem_busy(mem_busy), .mem_addr(mem_addr));
  mtp_master u_mtp_master (.core_clk(core_clk), .evt(evt), .resp(resp));
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task wrap_up;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task cmd(input logic [7:0] c, input logic [7:0] b0, input logic [7:0] b1, input int n, input logic [1:0] e);
    u_mtp_master.ev(12'h801);
    u_mtp_master.put(c, r);
    chk("cmd ack", 16'(r), 16'(e));
    if (n > 0) u_mtp_master.put(b0, r);
    if (n > 0) chk("byte ack", 16'(r), 16'(e));
    if (n > 1) u_mtp_master.put(b1, r);
    if (n > 1) chk("byte ack", 16'(r), 16'(e));
  endtask
  task rd(input logic [7:0] e);
    cmd(8'h14, 8'h00, 8'h00, 0, 2'b11);
    u_mtp_master.get(d);
    chk("read data", 16'(d), 16'(e));
    u_mtp_master.ev(12'h400);
  endtask
  task idle;
    u_mtp_master.ev(12'h400);
    repeat (4) @(posedge core_clk);
    repeat (40) if (mem_busy === 1'b1) @(posedge core_clk);
  endtask
  initial begin
    #1_000_000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    #1;
    chk("own addr", 16'(own_addr), 16'h0022);
    foreach (rows[i]) begin
      cmd(8'h10, rows[i].a[15:8], rows[i].a[7:0], 2, 2'b11);
      idle();
      chk("addr", mem_addr, rows[i].a);
      cmd(8'h12, rows[i].w, 8'h00, 1, 2'b11);
      idle();
      rd(rows[i].e);
    end
    cmd(8'h10, 8'h00, 8'h90, 2, 2'b11);
    idle();
    cmd(8'h12, 8'h5A, 8'h00, 1, 2'b11);
    u_mtp_master.ev(12'h400);
    cmd(8'h14, 8'h00, 8'h00, 0, 2'b10);
    cmd(8'h10, 8'h00, 8'h20, 2, 2'b10);
    chk("addr held", mem_addr, 16'h0090);
    chk("no read data", 16'(resp.rd_valid), 16'h0000);
    idle();
    rd(8'h5A);
    cmd(8'h12, 8'hC3, 8'h00, 1, 2'b11);
    u_mtp_master.ev(12'h400);
    cmd(8'h12, 8'h77, 8'h00, 1, 2'b10);
    idle();
    rd(8'hC3);
    cmd(8'h16, 8'h00, 8'h00, 0, 2'b00);
    idle();
    u_mtp_master.ev(12'h800);
    u_mtp_master.put(8'h10, r);
    chk("plain call", 16'(r), 16'h0000);
    idle();
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    #1;
    chk("addr reset", mem_addr, 16'h0000);
    chk("busy reset", 16'(mem_busy), 16'h0000);
    wrap_up();
  end
endmodule
`default_nettype wire
